// ===== rtl/csp_pkg.sv
package csp_pkg;

    // -----------------------------------------------------------------
    // Frame and word geometry
    // -----------------------------------------------------------------
    localparam int unsigned WORD_BITS  = 16;
    localparam int unsigned CNT_W      = 9;
    localparam logic [8:0]  FRAME_LAST = 9'h1ff;    // 512 clocks a frame
    localparam logic [8:0]  PRIM_START = 9'h000;
    localparam logic [8:0]  SEC_START  = 9'h100;
    localparam logic [3:0]  LAST_BIT   = 4'hf;

    // -----------------------------------------------------------------
    // Shift clock phases: four master clocks per shift clock
    // -----------------------------------------------------------------
    localparam int unsigned SCLK_BIT   = 1;
    localparam logic [1:0]  RISE_PHASE = 2'h0;
    localparam logic [1:0]  FALL_PHASE = 2'h2;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [1:0]  FLAG_RESET = 2'h0;

    typedef enum logic [2:0] {
        CSP_IDLE = 3'h1,
        CSP_PRIM = 3'h2,
        CSP_SEC  = 3'h4
    } csp_state_type;

endpackage

// ===== rtl/csp_timing_if.sv
interface csp_timing_if;
    logic sclk;
    logic rise;
    logic fall;
    logic prim_start;
    logic sec_start;

    modport gen (
        output sclk,
        output rise,
        output fall,
        output prim_start,
        output sec_start
    );

    modport use_side (
        input sclk,
        input rise,
        input fall,
        input prim_start,
        input sec_start
    );
endinterface

// ===== rtl/csp_frame_timer.sv
module csp_frame_timer (
    input  wire logic   mclk_i,
    input  wire logic   reset_i,
    csp_timing_if.gen   tim
);

    logic [8:0] cnt_q;
    logic [8:0] cnt_d;
    logic       sclk_q;
    logic       sclk_d;

    // ---------------------------------------------------------------
    // Frame counter, wraps every 512 master clocks
    // ---------------------------------------------------------------
    always_comb begin
        if (cnt_q == csp_pkg::FRAME_LAST) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + 9'h001;
        end
        // Shift clock built from the counter, so it is never a new domain
        sclk_d = ~cnt_d[csp_pkg::SCLK_BIT];
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cnt_q  <= '0;
            // Equals ~cnt[1] at count zero: no runt pulse after reset
            sclk_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_d;
            sclk_q <= sclk_d;
        end
    end

    assign tim.sclk       = sclk_q;
    assign tim.rise       = (cnt_q[1:0] == csp_pkg::RISE_PHASE);
    assign tim.fall       = (cnt_q[1:0] == csp_pkg::FALL_PHASE);
    assign tim.prim_start = (cnt_q == csp_pkg::PRIM_START);
    assign tim.sec_start  = (cnt_q == csp_pkg::SEC_START);

endmodule // csp_frame_timer

// ===== rtl/csp_serial_port.sv
// What this block does
// - Frame-sync goes low to open every transfer.
// - Frame-sync stays low while any bit is being shifted.
// - Data output is released whenever frame-sync is high.
// - Function code is latched as frame-sync rises after a primary frame.
// - Phone mode routes alternate data input to data output in secondary frames.
// - Phone mode drives both flag outputs from the programmed flag values.
// - DAC and command words are taken from data input on the shift clock.
// - ADC bits go out on data output on the shift clock.
// - One frame every 512 master clocks.
// - Samples are 16-bit two's-complement words both ways.
// - Every internal clock comes from the one master clock.
// - A transfer is 16 shift clocks, starting at frame-sync fall.
// - Shift clock is made from the master clock and times both lines.
// - Frame-sync rises on the sixteenth shift-clock rise after falling.
// - Secondary frames run only on a hardware or software request.
module csp_serial_port (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        din_i,
    input  wire logic        function_code_in_i,
    input  wire logic        alternate_data_in_i,
    input  wire logic        phone_mode_i,
    input  wire logic [1:0]  flag_value_i,
    input  wire logic [15:0] adc_sample_i,
    input  wire logic [15:0] sec_read_word_i,
    input  wire logic        sec_soft_req_i,
    output logic             sclk_o,
    output logic             frame_sync_n_o,
    output logic             dout_o,
    output logic             dout_oe_n_o,
    output logic             flag0_o,
    output logic             flag1_o,
    output logic             adc_take_o,
    output logic [15:0]      dac_sample_o,
    output logic             dac_valid_o,
    output logic [15:0]      sec_cmd_o,
    output logic             sec_cmd_valid_o,
    output logic             fc_latched_o,
    output logic             sec_pending_o
);

    // ---------------------------------------------------------------
    // Frame timing
    // ---------------------------------------------------------------
    csp_timing_if tim ();

    csp_frame_timer u_timer (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .tim     (tim)
    );

    // ---------------------------------------------------------------
    // Frame state
    // ---------------------------------------------------------------
    csp_pkg::csp_state_type state_q;
    csp_pkg::csp_state_type state_d;
    logic [3:0]             bitcnt_q;
    logic [3:0]             bitcnt_d;
    logic [15:0]            tx_q;
    logic [15:0]            tx_d;
    logic [15:0]            rx_q;
    logic [15:0]            rx_d;
    logic                   fsn_q;
    logic                   fsn_d;
    logic                   dout_q;
    logic                   dout_d;
    logic                   oe_n_q;
    logic                   oe_n_d;
    logic                   fc_q;
    logic                   fc_d;
    logic                   pend_q;
    logic                   pend_d;
    logic                   pend_set;
    logic                   pend_clr;
    logic [15:0]            dac_q;
    logic [15:0]            dac_d;
    logic                   dac_vld_q;
    logic                   dac_vld_d;
    logic [15:0]            cmd_q;
    logic [15:0]            cmd_d;
    logic                   cmd_vld_q;
    logic                   cmd_vld_d;
    logic                   take_q;
    logic                   take_d;
    logic [1:0]             flag_q;
    logic [1:0]             flag_d;
    logic                   close_now;
    logic                   sec_open;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Shift register contents once the top bit has gone out
    function automatic logic [15:0] shift_left(input logic [15:0] word);
        return {word[14:0], 1'b0};
    endfunction

    function automatic logic in_frame(input csp_pkg::csp_state_type st);
        return (st == csp_pkg::CSP_PRIM) || (st == csp_pkg::CSP_SEC);
    endfunction

    // ---------------------------------------------------------------
    // Frame strobes
    // ---------------------------------------------------------------
    always_comb begin
        close_now = in_frame(state_q) && tim.rise
                  && (bitcnt_q == csp_pkg::LAST_BIT);
        // Primary slot always wins over a pending secondary
        sec_open  = (state_q == csp_pkg::CSP_IDLE) && !tim.prim_start
                  && tim.sec_start && pend_q;
    end

    // ---------------------------------------------------------------
    // Frame control and shifting
    // ---------------------------------------------------------------
    always_comb begin
        state_d  = state_q;
        bitcnt_d = bitcnt_q;
        tx_d     = tx_q;
        rx_d     = rx_q;
        fsn_d    = fsn_q;
        dout_d   = dout_q;
        oe_n_d   = oe_n_q;
        take_d   = 1'b0;

        case (state_q)
            csp_pkg::CSP_IDLE: begin
                if (tim.prim_start) begin
                    // ADC word loaded at the opening shift-clock rise
                    state_d  = csp_pkg::CSP_PRIM;
                    fsn_d    = 1'b0;
                    oe_n_d   = 1'b0;
                    dout_d   = adc_sample_i[15];
                    tx_d     = shift_left(adc_sample_i);
                    bitcnt_d = '0;
                    take_d   = 1'b1;
                end else if (sec_open) begin
                    state_d  = csp_pkg::CSP_SEC;
                    fsn_d    = 1'b0;
                    oe_n_d   = 1'b0;
                    dout_d   = sec_read_word_i[15];
                    tx_d     = shift_left(sec_read_word_i);
                    bitcnt_d = '0;
                end
            end
            csp_pkg::CSP_PRIM,
            csp_pkg::CSP_SEC: begin
                // Host drives on our rise, so its bit is steady at our fall
                if (tim.fall) begin
                    rx_d = {rx_q[14:0], din_i};
                end
                if (close_now) begin
                    // Sixteenth rise: close the frame
                    state_d = csp_pkg::CSP_IDLE;
                    fsn_d   = 1'b1;
                    oe_n_d  = 1'b1;
                    dout_d  = 1'b0;
                end else if (tim.rise) begin
                    dout_d   = tx_q[15];
                    tx_d     = shift_left(tx_q);
                    bitcnt_d = bitcnt_q + 4'h1;
                end
            end
            default: begin
                state_d = csp_pkg::CSP_IDLE;
                fsn_d   = 1'b1;
                oe_n_d  = 1'b1;
                dout_d  = 1'b0;
            end
        endcase

        // Alternate data tracks with one clock of latency, not a bypass
        if ((state_d == csp_pkg::CSP_SEC) && phone_mode_i) begin
            dout_d = alternate_data_in_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q  <= csp_pkg::CSP_IDLE;
            bitcnt_q <= '0;
            tx_q     <= csp_pkg::WORD_RESET;
            rx_q     <= csp_pkg::WORD_RESET;
            fsn_q    <= 1'b1;
            dout_q   <= 1'b0;
            oe_n_q   <= 1'b1;
            take_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            bitcnt_q <= bitcnt_d;
            tx_q     <= tx_d;
            rx_q     <= rx_d;
            fsn_q    <= fsn_d;
            dout_q   <= dout_d;
            oe_n_q   <= oe_n_d;
            take_q   <= take_d;
        end
    end

    // ---------------------------------------------------------------
    // Received words and function code
    // ---------------------------------------------------------------
    always_comb begin
        fc_d      = fc_q;
        dac_d     = dac_q;
        dac_vld_d = 1'b0;
        cmd_d     = cmd_q;
        cmd_vld_d = 1'b0;
        if (close_now && (state_q == csp_pkg::CSP_PRIM)) begin
            fc_d      = function_code_in_i;
            dac_d     = rx_q;
            dac_vld_d = 1'b1;
        end else if (close_now) begin
            cmd_d     = rx_q;
            cmd_vld_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            fc_q      <= 1'b0;
            dac_q     <= csp_pkg::WORD_RESET;
            dac_vld_q <= 1'b0;
            cmd_q     <= csp_pkg::WORD_RESET;
            cmd_vld_q <= 1'b0;
        end else begin
            fc_q      <= fc_d;
            dac_q     <= dac_d;
            dac_vld_q <= dac_vld_d;
            cmd_q     <= cmd_d;
            cmd_vld_q <= cmd_vld_d;
        end
    end

    // ---------------------------------------------------------------
    // Secondary request
    // ---------------------------------------------------------------
    always_comb begin
        pend_set = sec_soft_req_i;
        if (close_now && (state_q == csp_pkg::CSP_PRIM)) begin
            pend_set = sec_soft_req_i | function_code_in_i;
        end
        pend_clr = sec_open;
        // Request arriving in the clearing cycle is kept
        pend_d   = (pend_q & ~pend_clr) | pend_set;
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // ---------------------------------------------------------------
    // Phone-mode flags
    // ---------------------------------------------------------------
    always_comb begin
        if (phone_mode_i) begin
            flag_d = flag_value_i;
        end else begin
            flag_d = csp_pkg::FLAG_RESET;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            flag_q <= csp_pkg::FLAG_RESET;
        end else begin
            flag_q <= flag_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign sclk_o          = tim.sclk;
    assign frame_sync_n_o  = fsn_q;
    assign dout_o          = dout_q;
    assign dout_oe_n_o     = oe_n_q;
    assign flag0_o         = flag_q[0];
    assign flag1_o         = flag_q[1];
    assign adc_take_o      = take_q;
    assign dac_sample_o    = dac_q;
    assign dac_valid_o     = dac_vld_q;
    assign sec_cmd_o       = cmd_q;
    assign sec_cmd_valid_o = cmd_vld_q;
    assign fc_latched_o    = fc_q;
    assign sec_pending_o   = pend_q;

endmodule // csp_serial_port

// ===== test/csp_serial_port_properties.sv
module csp_serial_port_properties (
    input wire logic       mclk_i,
    input wire logic       reset_i,
    input wire logic       alternate_data_in_i,
    input wire logic       phone_mode_i,
    input wire logic [1:0] flag_value_i,
    input wire logic       sclk_o,
    input wire logic       frame_sync_n_o,
    input wire logic       dout_o,
    input wire logic       dout_oe_n_o,
    input wire logic       flag0_o,
    input wire logic       flag1_o,
    input wire logic       adc_take_o,
    input wire logic       dac_valid_o,
    input wire logic       sec_cmd_valid_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    logic [6:0] low_q, low_d;
    logic       sec_q, sec_d;
    // Secondary frame marker: a low frame not opened by an ADC take
    always_comb begin
        low_d = frame_sync_n_o ? 7'h00 : low_q + 7'h01;
        sec_d = adc_take_o ? 1'b0 : (frame_sync_n_o ? 1'b1 : sec_q);
    end
    always_ff @(posedge mclk_i) begin
        low_q <= reset_i ? 7'h00 : low_d;
        sec_q <= reset_i ? 1'b0 : sec_d;
    end
    sequence sclk_high2; sclk_o [*2]; endsequence
    sequence sclk_low2; !sclk_o [*2]; endsequence
    fs_width_a: assert property (
        $rose(frame_sync_n_o) |-> low_q == 7'h40)
        else $error("frame sync low time is not 64 clocks");
    fs_bound_a: assert property (low_q <= 7'h40)
        else $error("frame sync held low too long");
    hiz_idle_a: assert property (frame_sync_n_o |-> !dout_o)
        else $error("data out not released while idle");
    oe_track_a: assert property (
        dout_oe_n_o == frame_sync_n_o)
        else $error("output enable does not follow frame sync");
    frame_rate_a: assert property (
        adc_take_o |-> ##[512:512] adc_take_o)
        else $error("primary frame spacing is not 512 clocks");
    prim_open_a: assert property (
        adc_take_o |-> $fell(frame_sync_n_o))
        else $error("primary take without frame sync fall");
    dac_close_a: assert property (
        dac_valid_o |-> $rose(frame_sync_n_o))
        else $error("word delivered away from frame end");
    cmd_close_a: assert property (
        sec_cmd_valid_o |-> $rose(frame_sync_n_o) && sec_q)
        else $error("command delivered away from secondary end");
    sclk_shape_a: assert property (
        $rose(sclk_o) |-> sclk_high2 ##1 sclk_low2 ##1 sclk_o)
        else $error("shift clock is not master clock over four");
    flag_out_a: assert property (
        !$past(reset_i) |-> {flag1_o, flag0_o} ==
        ($past(phone_mode_i) ? $past(flag_value_i) : 2'h0))
        else $error("flag outputs wrong");
    alt_route_a: assert property (
        !frame_sync_n_o && !adc_take_o && sec_q
        && phone_mode_i && $past(phone_mode_i)
        |-> dout_o == $past(alternate_data_in_i))
        else $error("alternate data not routed");
endmodule // csp_serial_port_properties

bind csp_serial_port csp_serial_port_properties u_props (.mclk_i, .reset_i,
    .alternate_data_in_i, .phone_mode_i, .flag_value_i, .sclk_o,
    .frame_sync_n_o, .dout_o, .dout_oe_n_o, .flag0_o, .flag1_o,
    .adc_take_o, .dac_valid_o, .sec_cmd_valid_o);

// ===== test/csp_host_model.sv
module csp_host_model (
    input  wire logic        mclk_i,
    input  wire logic        sclk_i,
    input  wire logic        frame_sync_n_i,
    input  wire logic        dout_i,
    input  wire logic [15:0] tx_word_i,
    output logic             din_o,
    output logic [15:0]      rx_word_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sclk_q = 1'b0;
    logic        fs_q = 1'b1;
    logic [15:0] tx_q = 16'h0000;
    initial din_o = 1'b0;
    initial rx_word_o = 16'h0000;
    // Idle data line toggles so a stale level never looks valid
    always @(negedge mclk_i) begin
        if (fs_q && !frame_sync_n_i) begin
            din_o <= tx_word_i[15];
            tx_q = tx_word_i << 1;
        end else if (!frame_sync_n_i && sclk_i && !sclk_q) begin
            din_o <= tx_q[15];
            tx_q = tx_q << 1;
        end else if (frame_sync_n_i) begin
            din_o <= ~din_o;
        end
        if (!frame_sync_n_i && !sclk_i && sclk_q) begin
            rx_word_o <= {rx_word_o[14:0], dout_i};
        end
        sclk_q = sclk_i;
        fs_q = frame_sync_n_i;
    end
endmodule // csp_host_model

// ===== test/test_codec_serial_port.sv
module test_codec_serial_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i = 1'b0, reset_i = 1'b1, function_code_in_i = 1'b0;
    logic        alternate_data_in_i = 1'b0, phone_mode_i = 1'b0;
    logic        sec_soft_req_i = 1'b0, din_i, hit;
    logic [1:0]  flag_value_i = 2'h0;
    logic [15:0] adc_sample_i = 16'h0000, sec_read_word_i = 16'h0000;
    logic [15:0] tx_word = 16'h0000, rx_word, dac_sample_o, sec_cmd_o;
    logic        sclk_o, frame_sync_n_o, dout_o, dout_oe_n_o, flag0_o;
    logic        flag1_o, adc_take_o, dac_valid_o, sec_cmd_valid_o;
    logic        fc_latched_o, sec_pending_o, exp_p;
    int          n_errors = 0, samples_checked = 0;
    always #2.5 mclk_i = ~mclk_i;
    always @(negedge mclk_i) alternate_data_in_i <= 1'($urandom);
    csp_serial_port u_dut (.mclk_i, .reset_i, .din_i, .function_code_in_i,
        .alternate_data_in_i, .phone_mode_i, .flag_value_i, .adc_sample_i,
        .sec_read_word_i, .sec_soft_req_i, .sclk_o, .frame_sync_n_o, .dout_o,
        .dout_oe_n_o, .flag0_o, .flag1_o, .adc_take_o, .dac_sample_o,
        .dac_valid_o, .sec_cmd_o, .sec_cmd_valid_o, .fc_latched_o,
        .sec_pending_o);
    csp_host_model u_host (.mclk_i, .sclk_i(sclk_o),
        .frame_sync_n_i(frame_sync_n_o), .dout_i(dout_o),
        .tx_word_i(tx_word), .din_o(din_i), .rx_word_o(rx_word));
    function automatic logic exp_pend(input logic fc, input logic sw);
        return fc | sw;
    endfunction
    function automatic logic [15:0] exp_flag(input logic pm,
                                             input logic [1:0] fv);
        return pm ? {14'h0, fv} : 16'h0000;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_fs(input logic lvl, input int lim, output logic h);
        h = 1'b0;
        repeat (lim) begin
            @(negedge mclk_i);
            if (frame_sync_n_o === lvl) begin
                h = 1'b1;
                break;
            end
        end
    endtask
    task automatic need(input logic lvl, input int lim);
        logic h;
        wait_fs(lvl, lim, h);
        if (!h) begin
            n_errors++;
            give_verdict();
        end
    endtask
    // ---------------------------------------------------------------
    // Frames: primary, then optional secondary; corner words mixed in
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'h70d9));
        repeat (4) @(negedge mclk_i);
        for (int i = 0; i < 10; i++) begin
            adc_sample_i = (i == 1) ? 16'h8000 : 16'($urandom);
            tx_word = (i == 2) ? 16'h7fff : 16'($urandom);
            sec_read_word_i = 16'($urandom);
            function_code_in_i = (i == 5) ? 1'b0 : 1'($urandom);
            sec_soft_req_i = (i == 4);
            phone_mode_i = (i >= 6);
            flag_value_i = 2'($urandom);
            exp_p = exp_pend(function_code_in_i, sec_soft_req_i);
            reset_i = 1'b0;
            need(1'b0, 600);
            need(1'b1, 80);
            sec_soft_req_i = 1'b0;
            chk(rx_word, adc_sample_i);
            chk(dac_sample_o, tx_word);
            chk({15'h0, fc_latched_o}, {15'h0, function_code_in_i});
            chk({15'h0, sec_pending_o}, {15'h0, exp_p});
            chk({14'h0, flag1_o, flag0_o},
                exp_flag(phone_mode_i, flag_value_i));
            tx_word = 16'($urandom);
            wait_fs(1'b0, 250, hit);
            chk({15'h0, hit}, {15'h0, exp_p});
            if (hit) begin
                need(1'b1, 80);
                chk(sec_cmd_o, tx_word);
                if (!phone_mode_i) chk(rx_word, sec_read_word_i);
            end
            $display("frame %0d done", i);
        end
        give_verdict();
    end
endmodule // test_codec_serial_port
